// *** design/ufpe_params.svh ***
// Purpose: Named constants for the UART frame, parity and error block
// Assumes: 200 MHz system clock
// Notes: Register offsets are byte addresses on APB
`ifndef UFPE_PARAMS_SVH
`define UFPE_PARAMS_SVH
`define UFPE_CLK_HZ 200000000
`define UFPE_BAUD 9575
`define UFPE_START_US 52
`define UFPE_OFS_CTRL 12'h000
`define UFPE_OFS_TXH 12'h004
`define UFPE_OFS_RXB 12'h008
`define UFPE_OFS_STAT 12'h00C
`define UFPE_OFS_IRQ 12'h010
`define UFPE_RXB_RST 8'hFF
`define UFPE_TXH_RST 8'hFF
`define UFPE_CTRL_TXE 0
`define UFPE_CTRL_RXE 1
`define UFPE_CTRL_LEN8 2
`define UFPE_CTRL_STOP2 3
`define UFPE_CTRL_PAR_LO 4
`define UFPE_CTRL_SUPP 6
`endif

// *** design/ufpe_pkg.sv ***
// Purpose: Types for the UART frame, parity and error block
// Assumes: ufpe_params.svh holds the numbers
// Notes: Parity codes follow the control register field
package ufpe_pkg;
	typedef enum logic [1:0] {
		UFPE_PAR_NONE = 2'h0,
		UFPE_PAR_ZERO = 2'h1,
		UFPE_PAR_ODD = 2'h2,
		UFPE_PAR_EVEN = 2'h3
	} ufpe_par_e;
	typedef struct packed {
		logic supp;
		ufpe_par_e par;
		logic stop2;
		logic len8;
		logic rxe;
		logic txe;
	} ufpe_cfg_s;
	typedef struct packed {
		logic ovr;
		logic frm;
		logic par;
	} ufpe_err_s;
endpackage : ufpe_pkg

// *** design/ufpe_tick.sv ***
// Purpose: Bit-rate and half-bit enable pulses
// Assumes: One clock, synchronous active-low reset
// Notes: Counter restarts on clr so bit centres track the start edge
`timescale 1ns/10ps
`default_nettype none
module ufpe_tick #(
	parameter int DIV = 20888
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	output logic tick,
	output logic half
);
	logic [15:0] cnt_ff;
	always_ff @(posedge clk) begin
		if (!rst_n || clr || tick) begin
			cnt_ff <= 16'h0000;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end
	assign tick = (cnt_ff == 16'(DIV - 1));
	assign half = (cnt_ff == 16'(DIV / 2 - 1));
endmodule : ufpe_tick
`default_nettype wire

// *** design/ufpe_uart.sv ***
// Purpose: UART frame formatting, parity and receive errors with an APB slave
// Assumes: RXD synchronous to CLK_SYS; zero-wait APB
// Notes: Software reads status before the receive buffer
`timescale 1ns/10ps
`default_nettype none
`include "ufpe_params.svh"
module ufpe_uart import ufpe_pkg::*; #(
	parameter int CLK_HZ = `UFPE_CLK_HZ,
	parameter int BAUD = `UFPE_BAUD
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic RXD,
	output logic TXD,
	output logic IRQ
);
	localparam int DIV = CLK_HZ / BAUD;
	localparam int START_CYC = (CLK_HZ / 1000000) * `UFPE_START_US;
	typedef enum logic [4:0] {
		UFPE_TX_IDLE = 5'h01, UFPE_TX_START = 5'h02, UFPE_TX_DATA = 5'h04,
		UFPE_TX_PAR = 5'h08, UFPE_TX_STOP = 5'h10
	} ufpe_tx_e;
	typedef enum logic [4:0] {
		UFPE_RX_IDLE = 5'h01, UFPE_RX_CHK = 5'h02, UFPE_RX_DATA = 5'h04,
		UFPE_RX_PAR = 5'h08, UFPE_RX_STOP = 5'h10
	} ufpe_rx_e;
	ufpe_cfg_s cfg_ff;
	ufpe_err_s err_ff;
	ufpe_tx_e tx_state_ff;
	ufpe_rx_e rx_state_ff;
	logic [7:0] uart_transmit_holding_ff;
	logic [7:0] uart_receive_buffer_ff;
	logic [7:0] tx_sh_ff;
	logic [7:0] rx_sh_ff;
	logic [2:0] tx_cnt_ff;
	logic [2:0] rx_cnt_ff;
	logic tx_go_ff;
	logic tx_par_ff;
	logic tx_stop_ff;
	logic rx_par_ff;
	logic rx_full_ff;
	logic serial_unit_irq_flag_ff;
	logic txd_ff;
	logic [31:0] prdata_ff;
	logic [15:0] chk_ff;
	logic wr;
	logic rd;
	logic tx_tick;
	logic rx_tick;
	logic tx_done;
	logic rx_done;
	logic rx_fail;
	logic rx_last;
	logic tx_last;
	logic [7:0] rx_char;
	logic rx_perr;
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && PENABLE && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign PRDATA = prdata_ff;
	assign TXD = txd_ff;
	assign IRQ = serial_unit_irq_flag_ff;
	ufpe_tick #(.DIV(DIV)) u_tx_tick (
		.clk(CLK_SYS), .rst_n(RST_N), .clr(tx_state_ff == UFPE_TX_IDLE),
		.tick(tx_tick), .half()
	);
	ufpe_tick #(.DIV(DIV)) u_rx_tick (
		.clk(CLK_SYS), .rst_n(RST_N), .clr(rx_state_ff == UFPE_RX_IDLE || rx_state_ff == UFPE_RX_CHK),
		.tick(rx_tick), .half()
	);
	// Configuration register
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			cfg_ff <= '0;
		end else if (wr && PADDR == `UFPE_OFS_CTRL) begin
			cfg_ff <= ufpe_cfg_s'(PWDATA[`UFPE_CTRL_SUPP:`UFPE_CTRL_TXE]);
		end
	end
	// Holding write starts a frame when the transmitter is enabled
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			uart_transmit_holding_ff <= `UFPE_TXH_RST;
			tx_go_ff <= 1'b0;
		end else if (wr && PADDR == `UFPE_OFS_TXH) begin
			uart_transmit_holding_ff <= PWDATA[7:0];
			tx_go_ff <= cfg_ff.txe;
		end else if (tx_state_ff == UFPE_TX_IDLE) begin
			tx_go_ff <= 1'b0;
		end
	end
	assign tx_last = (tx_cnt_ff == (cfg_ff.len8 ? 3'h7 : 3'h6));
	assign tx_done = tx_tick && tx_state_ff == UFPE_TX_STOP && (tx_stop_ff || !cfg_ff.stop2);
	// Transmitter
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			tx_state_ff <= UFPE_TX_IDLE;
			txd_ff <= 1'b1;
			tx_sh_ff <= 8'h00;
			tx_cnt_ff <= 3'h0;
			tx_par_ff <= 1'b0;
			tx_stop_ff <= 1'b0;
		end else begin
			case (tx_state_ff)
				UFPE_TX_IDLE: begin
					txd_ff <= 1'b1;
					if (tx_go_ff) begin
						tx_sh_ff <= {cfg_ff.len8 & uart_transmit_holding_ff[7],
							uart_transmit_holding_ff[6:0]};
						tx_par_ff <= (cfg_ff.len8 & uart_transmit_holding_ff[7])
							^ (^uart_transmit_holding_ff[6:0]);
						txd_ff <= 1'b0;
						tx_cnt_ff <= 3'h0;
						tx_stop_ff <= 1'b0;
						tx_state_ff <= UFPE_TX_START;
					end
				end
				UFPE_TX_START: if (tx_tick) begin
					txd_ff <= tx_sh_ff[0];
					tx_state_ff <= UFPE_TX_DATA;
				end
				UFPE_TX_DATA: if (tx_tick) begin
					tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
					tx_cnt_ff <= tx_cnt_ff + 3'h1;
					if (!tx_last) begin
						txd_ff <= tx_sh_ff[1];
					end else if (cfg_ff.par == UFPE_PAR_NONE) begin
						txd_ff <= 1'b1;
						tx_state_ff <= UFPE_TX_STOP;
					end else begin
						case (cfg_ff.par)
							UFPE_PAR_EVEN: txd_ff <= tx_par_ff;
							UFPE_PAR_ODD: txd_ff <= ~tx_par_ff;
							default: txd_ff <= 1'b0;
						endcase
						tx_state_ff <= UFPE_TX_PAR;
					end
				end
				UFPE_TX_PAR: if (tx_tick) begin
					txd_ff <= 1'b1;
					tx_state_ff <= UFPE_TX_STOP;
				end
				UFPE_TX_STOP: if (tx_tick) begin
					tx_stop_ff <= 1'b1;
					if (tx_done) begin
						tx_state_ff <= UFPE_TX_IDLE;
					end
				end
				default: tx_state_ff <= UFPE_TX_IDLE;
			endcase
		end
	end
	assign rx_last = (rx_cnt_ff == (cfg_ff.len8 ? 3'h7 : 3'h6));
	assign rx_char = cfg_ff.len8 ? rx_sh_ff : {1'b0, rx_sh_ff[7:1]};
	assign rx_done = rx_tick && rx_state_ff == UFPE_RX_STOP;
	assign rx_fail = rx_done && !RXD;
	// Receiver; the bit counter restarts at the start check, which sits mid start bit,
	// so every later full-bit tick lands mid-bit; a half count would hit bit edges
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || !cfg_ff.rxe) begin
			rx_state_ff <= UFPE_RX_IDLE;
			chk_ff <= 16'h0000;
			rx_sh_ff <= 8'h00;
			rx_cnt_ff <= 3'h0;
			rx_par_ff <= 1'b0;
		end else begin
			case (rx_state_ff)
				UFPE_RX_IDLE: begin
					chk_ff <= 16'h0000;
					if (!RXD) begin
						rx_state_ff <= UFPE_RX_CHK;
					end
				end
				UFPE_RX_CHK: begin
					chk_ff <= chk_ff + 16'h0001;
					if (chk_ff == 16'(START_CYC - 1)) begin
						rx_state_ff <= RXD ? UFPE_RX_IDLE : UFPE_RX_DATA;
						rx_cnt_ff <= 3'h0;
						rx_par_ff <= 1'b0;
					end
				end
				UFPE_RX_DATA: if (rx_tick) begin
					rx_sh_ff <= {RXD, rx_sh_ff[7:1]};
					rx_par_ff <= rx_par_ff ^ RXD;
					rx_cnt_ff <= rx_cnt_ff + 3'h1;
					if (rx_last) begin
						rx_state_ff <= (cfg_ff.par == UFPE_PAR_NONE) ? UFPE_RX_STOP : UFPE_RX_PAR;
					end
				end
				UFPE_RX_PAR: if (rx_tick) begin
					rx_par_ff <= rx_par_ff ^ RXD;
					rx_state_ff <= UFPE_RX_STOP;
				end
				UFPE_RX_STOP: if (rx_tick) begin
					rx_state_ff <= UFPE_RX_IDLE;
				end
				default: rx_state_ff <= UFPE_RX_IDLE;
			endcase
		end
	end
	always_comb begin
		case (cfg_ff.par)
			UFPE_PAR_EVEN: rx_perr = rx_par_ff;
			UFPE_PAR_ODD: rx_perr = ~rx_par_ff;
			default: rx_perr = 1'b0;
		endcase
	end
	// Receive buffer and error status; an arriving error beats the read clear
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			uart_receive_buffer_ff <= `UFPE_RXB_RST;
			rx_full_ff <= 1'b0;
			err_ff <= '0;
		end else begin
			if (rd && PADDR == `UFPE_OFS_RXB) begin
				err_ff <= '0;
				rx_full_ff <= 1'b0;
			end
			if (rx_done) begin
				uart_receive_buffer_ff <= rx_char;
				rx_full_ff <= 1'b1;
				err_ff <= '{ovr: rx_full_ff, frm: rx_fail, par: rx_perr};
			end
		end
	end
	// Single request flag; written one clears it, a new completion wins
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			serial_unit_irq_flag_ff <= 1'b0;
		end else if (tx_done || (rx_done
			&& !(cfg_ff.supp && (rx_fail || rx_perr || rx_full_ff)))) begin
			serial_unit_irq_flag_ff <= 1'b1;
		end else if (wr && PADDR == `UFPE_OFS_IRQ && PWDATA[0]) begin
			serial_unit_irq_flag_ff <= 1'b0;
		end
	end
	// Read data; unmapped addresses read zero
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			prdata_ff <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			case (PADDR)
				`UFPE_OFS_CTRL: prdata_ff <= {25'h0, cfg_ff};
				`UFPE_OFS_TXH: prdata_ff <= {24'h0, uart_transmit_holding_ff};
				`UFPE_OFS_RXB: prdata_ff <= {24'h0, uart_receive_buffer_ff};
				`UFPE_OFS_STAT: prdata_ff <= {28'h0, rx_full_ff, err_ff};
				`UFPE_OFS_IRQ: prdata_ff <= {31'h0, serial_unit_irq_flag_ff};
				default: prdata_ff <= 32'h0000_0000;
			endcase
		end
	end
	property p_idle_high;
		@(posedge CLK_SYS) disable iff (!RST_N)
		tx_state_ff == UFPE_TX_IDLE && !tx_go_ff |=> TXD;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("txd not idle high");
	property p_start_low;
		@(posedge CLK_SYS) disable iff (!RST_N)
		tx_state_ff == UFPE_TX_START |-> !TXD;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");
	property p_rxclr;
		@(posedge CLK_SYS) disable iff (!RST_N)
		rd && PADDR == `UFPE_OFS_RXB && !rx_done |=> err_ff == '0;
	endproperty
	a_rxclr: assert property (p_rxclr) else $error("status not cleared");
	property p_frm;
		@(posedge CLK_SYS) disable iff (!RST_N)
		rx_done && !RXD |=> err_ff.frm;
	endproperty
	a_frm: assert property (p_frm) else $error("framing error missed");
	property p_ovr;
		@(posedge CLK_SYS) disable iff (!RST_N)
		rx_done && rx_full_ff |=> err_ff.ovr;
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun missed");
	property p_nopar;
		@(posedge CLK_SYS) disable iff (!RST_N)
		rx_done && cfg_ff.par[1] == 1'b0 |=> !err_ff.par;
	endproperty
	a_nopar: assert property (p_nopar) else $error("bad parity error");
	property p_len7;
		@(posedge CLK_SYS) disable iff (!RST_N)
		rx_done && !cfg_ff.len8 |=> !uart_receive_buffer_ff[7];
	endproperty
	a_len7: assert property (p_len7) else $error("bit7 not zero");
	property p_store;
		@(posedge CLK_SYS) disable iff (!RST_N)
		rx_done |=> rx_full_ff;
	endproperty
	a_store: assert property (p_store) else $error("char not stored");
	property p_irq;
		@(posedge CLK_SYS) disable iff (!RST_N)
		tx_done |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("tx completion lost");
endmodule : ufpe_uart
`default_nettype wire

// *** tb/ufpe_remote.sv ***
// Purpose: Remote asynchronous transceiver on the serial lines
// Assumes: BIT is one bit time in system clocks
// Notes: Receive line idles high, its documented rest level
`timescale 1ns/10ps
`default_nettype none
module ufpe_remote #(
	parameter int BIT = 208
) (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	initial rxd = 1'b1;
	// Index 0 leaves first: start, data, parity, stops
	task automatic send(input logic [11:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge clk);
		end
		// Line stays at the last bit sent, a stop or idle one, so frames may follow at once
	endtask : send
	// Short low pulse that must not count as a start bit
	task automatic glitch(input int len);
		rxd <= 1'b0;
		repeat (len) @(posedge clk);
		rxd <= 1'b1;
	endtask : glitch
	// Centre sampling; ok stays low when no start edge came
	task automatic grab(output logic [11:0] f, output logic ok);
		int t;
		t = 0;
		while (txd === 1'b1 && t < 40000) begin
			@(posedge clk);
			t++;
		end
		ok = (txd === 1'b0);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 12; i++) begin
			f[i] = txd;
			repeat (BIT) @(posedge clk);
		end
	endtask : grab
endmodule : ufpe_remote
`default_nettype wire

// *** tb/ufpe_uart_tb.sv ***
// Purpose: Self-checking bench for the UART frame, parity and error block
// Assumes: Lowered clock parameter gives 208 clocks a bit, start check 104
// Notes: Status is read before the receive buffer for each received frame
`timescale 1ns/10ps
`default_nettype none
`include "ufpe_params.svh"
module ufpe_uart_tb import ufpe_pkg::*;;
	localparam int CLK_HZ = 2000000;
	localparam int BIT = CLK_HZ / `UFPE_BAUD;
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY, PSLVERR, RXD, TXD, IRQ;
	int miscompares = 0;
	int checks_done = 0;
	always #2.5 CLK_SYS = ~CLK_SYS;
	ufpe_uart #(.CLK_HZ(CLK_HZ), .BAUD(`UFPE_BAUD)) uut (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
	ufpe_remote #(.BIT(BIT)) u_rem (.clk(CLK_SYS), .txd(TXD), .rxd(RXD));
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int t;
		t = 0;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			t++;
		end while (PREADY !== 1'b1 && t < 50);
		if (PREADY !== 1'b1) begin
			miscompares++;
			results();
		end
		chk("pslverr", {31'h0, PSLVERR}, 32'h0);
		rd = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK_SYS);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		apb(1'b1, a, d, x);
	endtask : wr
	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(n, r, e);
	endtask : rchk
	// Expected line bits, start first; idle ones pad the tail
	function automatic logic [11:0] frame(input logic [7:0] d, input logic l8,
		input logic [1:0] p);
		logic [11:0] f;
		int n;
		f = 12'hFFF;
		n = l8 ? 8 : 7;
		f[0] = 1'b0;
		for (int i = 0; i < n; i++) f[i + 1] = d[i];
		if (p == UFPE_PAR_ZERO) f[n + 1] = 1'b0;
		if (p[1]) f[n + 1] = (^(d & (l8 ? 8'hFF : 8'h7F))) ^ ~p[0];
		return f;
	endfunction : frame
	initial begin
		repeat (90000) @(posedge CLK_SYS);
		miscompares++;
		results();
	end
	initial begin
		// Case layout: data 13:6, len8 5, parity 4:3, flip parity 2, low stop 1, suppress 0
		logic [13:0] cs [9] = '{14'h2978, 14'h297C, 14'h0F30, 14'h0F34, 14'h0F2C,
			14'h0F20, 14'h297A, 14'h3558, 14'h297D};
		logic [13:0] v;
		logic [11:0] f;
		logic ok;
		int n;
		repeat (5) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		@(posedge CLK_SYS);
		rchk("rxb_rst", `UFPE_OFS_RXB, 32'hFF);
		rchk("txh_rst", `UFPE_OFS_TXH, 32'hFF);
		rchk("stat_rst", `UFPE_OFS_STAT, 32'h0);
		rchk("unmapped", 12'h014, 32'h0);
		chk("txd_idle", {31'h0, TXD}, 32'h1);
		$display("test reset done");
		for (int c = 0; c < 8; c++) begin
			wr(`UFPE_OFS_CTRL, {26'h0, c[2:1], c[0], c[0], 2'h1});
			wr(`UFPE_OFS_IRQ, 32'h1);
			wr(`UFPE_OFS_TXH, 32'hD3);
			u_rem.grab(f, ok);
			if (!ok) begin
				miscompares++;
				results();
			end
			chk("tx_frame", {20'h0, f}, {20'h0, frame(8'hD3, c[0], c[2:1])});
			repeat (2 * BIT) @(posedge CLK_SYS);
			chk("tx_idle", {31'h0, TXD}, 32'h1);
			chk("tx_irq_pin", {31'h0, IRQ}, 32'h1);
			rchk("tx_irq", `UFPE_OFS_IRQ, 32'h1);
		end
		$display("test transmit done");
		for (int k = 0; k < 9; k++) begin
			v = cs[k];
			wr(`UFPE_OFS_CTRL, {25'h0, v[0], v[4:3], 1'b0, v[5], 2'h2});
			wr(`UFPE_OFS_IRQ, 32'h1);
			f = frame(v[13:6], v[5], v[4:3]);
			n = v[5] ? 8 : 7;
			if (v[2]) f[n + 1] = ~f[n + 1];
			if (v[1]) f[n + 1 + int'(v[4:3] != UFPE_PAR_NONE)] = 1'b0;
			u_rem.send(f, 12);
			rchk("rx_stat", `UFPE_OFS_STAT, {28'h0, 2'h2, v[1], v[2] & v[4]});
			rchk("rx_data", `UFPE_OFS_RXB, {24'h0, (v[5] ? v[13:6] : {1'b0, v[12:6]})});
			rchk("rx_clear", `UFPE_OFS_STAT, 32'h0);
			rchk("rx_irq", `UFPE_OFS_IRQ, {31'h0, ~(v[0] & (v[2] & v[4] | v[1]))});
			chk("rx_irq_pin", {31'h0, IRQ}, {31'h0, ~(v[0] & (v[2] & v[4] | v[1]))});
		end
		$display("test receive done");
		wr(`UFPE_OFS_CTRL, 32'h3E);
		u_rem.send(frame(8'h5A, 1'b1, UFPE_PAR_EVEN), 11);
		u_rem.send(frame(8'hC3, 1'b1, UFPE_PAR_EVEN), 12);
		rchk("ovr_stat", `UFPE_OFS_STAT, 32'hC);
		rchk("ovr_data", `UFPE_OFS_RXB, 32'hC3);
		// Low for half the start check time, then back to idle
		u_rem.glitch(BIT / 4);
		// Long enough for a falsely started frame to complete and show as full
		repeat (12 * BIT) @(posedge CLK_SYS);
		rchk("glitch", `UFPE_OFS_STAT, 32'h0);
		$display("test overrun and start check done");
		results();
	end
endmodule : ufpe_uart_tb
`default_nettype wire
